// ==== hdl/fwsf_pkg.sv ====
// Purpose: Constants for the fault and warning status flag bank
// Assumes: Command codes and field positions of the status registers
// Notes:   All flag registers reset to zero
package fwsf_pkg;
	localparam logic [7:0] FWSF_CMD_IOUT  = 8'h7B;
	localparam logic [7:0] FWSF_CMD_INPUT = 8'h7C;
	localparam logic [7:0] FWSF_CMD_TEMP  = 8'h7D;
	localparam logic [7:0] FWSF_RESET_VAL = 8'h00;
	localparam int FWSF_IOUT_FAULT_BIT  = 7;
	localparam int FWSF_IOUT_WARN_BIT   = 5;
	localparam int FWSF_VIN_OV_F_BIT    = 7;
	localparam int FWSF_VIN_OV_W_BIT    = 6;
	localparam int FWSF_VIN_UV_W_BIT    = 5;
	localparam int FWSF_VIN_UV_F_BIT    = 4;
	localparam int FWSF_PIN_OP_W_BIT    = 0;
	localparam int FWSF_OVERTEMPERATURE_FAULT_BIT    = 7;
	localparam int FWSF_OT_WARN_BIT     = 6;
	localparam int FWSF_SUM_IOUT_BIT    = 14;
	localparam int FWSF_SUM_INPUT_BIT   = 13;
	localparam logic [7:0] FWSF_IOUT_MASK  = 8'hA0;
	localparam logic [7:0] FWSF_INPUT_MASK = 8'hF1;
	localparam logic [7:0] FWSF_TEMP_MASK  = 8'hC0;
endpackage

// ==== hdl/fwsf_if.sv ====
// Purpose: Carrier between the flag bank top and its latch module
// Assumes: Single core clock domain
// Notes:   Set is per-bit; clear is one signal for the whole register
`timescale 1ns/10ps
interface fwsf_if;
	logic [7:0] set_bits;
	logic       clear;
	logic [7:0] flags;
	modport owner (output set_bits, output clear, input flags);
	modport latch (input set_bits, input clear, output flags);
endinterface

// ==== hdl/fwsf_latch.sv ====
// Purpose: One 8-bit sticky flag register
// Assumes: Set events are synchronous to core_clk
// Notes:   Reserved bits are masked to zero by parameter
`timescale 1ns/10ps
module fwsf_latch #(
	parameter logic [7:0] MASK = 8'hFF
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// Flag carrier
	fwsf_if.latch     lf
);
	import fwsf_pkg::*;
	logic [7:0] flags_r;
	logic [7:0] flags_nxt;
	assign flags_nxt = ((lf.clear ? 8'h00 : flags_r) | lf.set_bits) & MASK;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			flags_r <= FWSF_RESET_VAL;
		end else begin
			flags_r <= flags_nxt;
		end
	end
	assign lf.flags = flags_r;
endmodule

// ==== hdl/fwsf_top.sv ====
// Purpose: Latched fault and warning status registers of a hot swap monitor
// Assumes: Event inputs are on core_clk; sense pins are asynchronous
// Notes:   Flags are read through a command-code read port
`timescale 1ns/10ps
module fwsf_top (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       reset,
	// Protection and monitor events, core_clk domain
	input  wire logic       gate_timer_shutdown,
	input  wire logic       output_current_over_warn,
	input  wire logic       input_voltage_over_warn,
	input  wire logic       input_voltage_under_warn,
	input  wire logic       input_power_over_warn,
	input  wire logic       temperature_over_fault,
	input  wire logic       temperature_over_warn,
	// Comparator pins, asynchronous
	input  wire logic       high_input_sense_pin,
	input  wire logic       low_input_sense_pin,
	// Host read and clear port
	input  wire logic       rd_en,
	input  wire logic [7:0] rd_cmd,
	input  wire logic       clear_status,
	output logic      [7:0] rd_data,
	output logic            rd_valid,
	output logic            rd_unsupported,
	// Status word summary
	output logic      [15:0] status_word_summary
);
	import fwsf_pkg::*;

	logic [1:0] ov_sync_r;
	logic [1:0] uv_sync_r;
	// Pins cross two flops before any logic sees them
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ov_sync_r <= 2'h0;
			uv_sync_r <= 2'h0;
		end else begin
			ov_sync_r <= {ov_sync_r[0], high_input_sense_pin};
			uv_sync_r <= {uv_sync_r[0], low_input_sense_pin};
		end
	end

	fwsf_if iout_c ();
	fwsf_if input_c ();
	fwsf_if temp_c ();

	assign iout_c.set_bits[FWSF_IOUT_FAULT_BIT] = gate_timer_shutdown;
	assign iout_c.set_bits[FWSF_IOUT_WARN_BIT] = output_current_over_warn;
	assign iout_c.set_bits[6] = 1'b0;
	assign iout_c.set_bits[4:0] = 5'h00;

	assign input_c.set_bits[FWSF_VIN_OV_F_BIT] = ov_sync_r[1];
	assign input_c.set_bits[FWSF_VIN_OV_W_BIT] = input_voltage_over_warn;
	assign input_c.set_bits[FWSF_VIN_UV_W_BIT] = input_voltage_under_warn;
	assign input_c.set_bits[FWSF_VIN_UV_F_BIT] = uv_sync_r[1];
	assign input_c.set_bits[3:1] = 3'h0;
	assign input_c.set_bits[FWSF_PIN_OP_W_BIT] = input_power_over_warn;

	assign temp_c.set_bits[FWSF_OVERTEMPERATURE_FAULT_BIT] = temperature_over_fault;
	assign temp_c.set_bits[FWSF_OT_WARN_BIT] = temperature_over_warn;
	assign temp_c.set_bits[5:0] = 6'h00;

	assign iout_c.clear  = clear_status;
	assign input_c.clear = clear_status;
	assign temp_c.clear  = clear_status;

	// Masks keep reserved bits zero even if a set path is miswired
	fwsf_latch #(.MASK(FWSF_IOUT_MASK)) u_iout (
		.core_clk (core_clk),
		.reset    (reset),
		.lf       (iout_c.latch)
	);
	fwsf_latch #(.MASK(FWSF_INPUT_MASK)) u_input (
		.core_clk (core_clk),
		.reset    (reset),
		.lf       (input_c.latch)
	);
	fwsf_latch #(.MASK(FWSF_TEMP_MASK)) u_temp (
		.core_clk (core_clk),
		.reset    (reset),
		.lf       (temp_c.latch)
	);

	wire logic       hit_iout  = (rd_cmd == FWSF_CMD_IOUT);
	wire logic       hit_input = (rd_cmd == FWSF_CMD_INPUT);
	wire logic       hit_temp  = (rd_cmd == FWSF_CMD_TEMP);
	wire logic       hit_any   = hit_iout | hit_input | hit_temp;
	wire logic [7:0] sel_data  = hit_iout  ? iout_c.flags  :
	                             hit_input ? input_c.flags :
	                             hit_temp  ? temp_c.flags  : 8'h00;

	wire logic [15:0] sum_iout_w  = 16'h0001 << FWSF_SUM_IOUT_BIT;
	wire logic [15:0] sum_input_w = 16'h0001 << FWSF_SUM_INPUT_BIT;
	wire logic [15:0] summary_nxt = (sum_iout_w & {16{|iout_c.flags}}) |
		(sum_input_w & {16{|input_c.flags}});

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rd_data             <= FWSF_RESET_VAL;
			rd_valid            <= 1'b0;
			rd_unsupported      <= 1'b0;
			status_word_summary <= 16'h0000;
		end else begin
			rd_data             <= rd_en ? sel_data : 8'h00;
			rd_valid            <= rd_en & hit_any;
			rd_unsupported      <= rd_en & ~hit_any;
			status_word_summary <= summary_nxt;
		end
	end
endmodule

// ==== test/fwsf_monitor.sv ====
// Purpose: Port assertions for the flag bank. Assumes: One clock.
// Notes: The async high reset disables every check
`timescale 1ns/10ps
module fwsf_monitor (
	input wire logic	core_clk,
	input wire logic	reset,
	input wire logic	clear_status,
	input wire logic	rd_en,
	input wire logic [7:0]	rd_cmd,
	input wire logic [7:0]	rd_data,
	input wire logic	rd_valid,
	input wire logic	rd_unsupported,
	input wire logic [15:0]	status_word_summary
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	wire hit = rd_en && rd_cmd >= 8'h7B && rd_cmd <= 8'h7D;
	read_ack_a: assert property (hit |=> rd_valid)
		else $error("no ack");
	bad_code_a: assert property (rd_en && !hit |=> rd_unsupported)
		else $error("no refusal");
	idle_zero_a: assert property (!rd_en |=> !rd_data && !rd_valid)
		else $error("idle data");
	iout_zero_a: assert property
		(hit && rd_cmd == 8'h7B |=> !(rd_data & 8'h5F))
		else $error("iout reserved");
	input_zero_a: assert property
		(hit && rd_cmd == 8'h7C |=> !rd_data[3:1])
		else $error("input reserved");
	temp_zero_a: assert property
		(hit && rd_cmd == 8'h7D |=> !rd_data[5:0])
		else $error("temp reserved");
	word_zero_a: assert property
		(!(status_word_summary & 16'h9FFF))
		else $error("word reserved");
	one_answer_a: assert property
		(rd_unsupported |-> !rd_valid && !rd_data)
		else $error("mixed answer");
	// Summary trails the flags by one cycle, so look one clear back
	iout_hold_a: assert property
		(status_word_summary[14] && !$past(clear_status)
		|=> status_word_summary[14])
		else $error("iout flag lost");
	input_hold_a: assert property
		(status_word_summary[13] && !$past(clear_status)
		|=> status_word_summary[13])
		else $error("input flag lost");
endmodule
bind fwsf_top fwsf_monitor mon (.core_clk, .reset, .clear_status, .rd_en,
	.rd_cmd, .rd_data, .rd_valid, .rd_unsupported, .status_word_summary);

// ==== test/fwsf_host.sv ====
// Purpose: Host that reads the flag bank. Assumes: Called after an edge.
// Notes: Request held through the taking edge, answer taken just after it
`timescale 1ns/10ps
module fwsf_host (
	input wire logic	core_clk,
	output logic	rd_en,
	output logic [7:0]	rd_cmd,
	input wire logic [7:0]	rd_data,
	input wire logic	rd_valid,
	input wire logic	rd_unsupported
);
	initial {rd_en, rd_cmd} = 9'h000;
	// Back to back reads keep rd_en high, so no double assignment
	task automatic rd(logic [7:0] c, output logic [9:0] r);
		{rd_en, rd_cmd} = {1'b1, c};
		@(posedge core_clk);
		#2 r = {rd_valid, rd_unsupported, rd_data};
	endtask
	// Drop the request so idle cycles are seen between bursts
	task automatic idle();
		{rd_en, rd_cmd} = 9'h000;
	endtask
endmodule

// ==== test/fault_warning_status_flags_bench.sv ====
// Purpose: Flag bank against a bit model. Assumes: Pins settle in 2 cycles.
// Notes: Events last one cycle; a clear every third round
`timescale 1ns/10ps
module fault_warning_status_flags_bench;
	logic	core_clk = 0, reset = 1, clear_status = 0;
	logic [8:0]	ev = 9'h000;
	logic [23:0]	m = 24'h000000;
	logic [9:0]	r, e;
	wire [7:0]	rd_cmd, rd_data;
	wire	rd_en, rd_valid, rd_unsupported;
	wire [15:0]	status_word_summary;
	int	errors = 0, n_compared = 0;
	fwsf_top uut (.core_clk, .reset, .clear_status, .rd_en, .rd_cmd, .rd_data,
		.rd_valid, .rd_unsupported, .status_word_summary, .gate_timer_shutdown(ev[8]),
		.output_current_over_warn(ev[7]), .high_input_sense_pin(ev[6]),
		.input_voltage_over_warn(ev[5]), .input_voltage_under_warn(ev[4]),
		.low_input_sense_pin(ev[3]), .input_power_over_warn(ev[2]),
		.temperature_over_fault(ev[1]), .temperature_over_warn(ev[0]));
	fwsf_host host (.core_clk, .rd_en, .rd_cmd, .rd_data, .rd_valid, .rd_unsupported);
	initial forever #12.5 core_clk = ~core_clk;
	initial #60000 test_done(1);
	task automatic chk(string nm, logic [15:0] s, logic [15:0] w);
		n_compared++;
		errors += int'(s !== w);
		if (s !== w) $display("CHECK FAILED %s exp %h seen %h", nm, w, s);
	endtask
	task automatic test_done(int late);
		errors += late;
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		void'($urandom(32'hC8AAD575));
		#202 reset = 0;
		for (int i = 0; i < 40; i++) begin
			@(posedge core_clk) #2 ev = i ? 9'($urandom & $urandom) : 9'h000;
			if (clear_status) m = 24'h000000;
			m |= {ev[8], 1'b0, ev[7], 5'h0, ev[6:3], 3'h0, ev[2:0], 6'h0};
			@(posedge core_clk) #2 ev = 9'h000;
			// Clear also meets the event edge, where the set must win
			clear_status = 0;
			for (int k = 0; k < 5; k++) begin
				host.rd(8'h7A + 8'(k), r);
				e = k % 4 ? {2'b10, m[24 - 8 * k +: 8]} : 10'h100;
				chk("read", r, e); // to
			end
			host.idle();
			e = {1'b0, |m[23:16], |m[15:8], 7'h00};
			chk("word", status_word_summary, {e, 6'h00});
			clear_status = (i % 3 == 2);
			// A mid-run reset must wipe every latched flag
			if (i == 20) begin
				reset = 1;
				m = 24'h000000;
				#25 reset = 0;
			end
			$display("round %0d done", i);
		end
		test_done(0);
	end
endmodule
